// ==== rtl/pwb_pkg.sv ====
/*
 * Constants for the buffered PWM period / pulse-width block.
 * Assumes one system clock and the plain register port of pwb_top.
 */
// Operation
// (RL1) enabled: period buffer loads at period end
// (RL2) disabled: period buffer loads next clock
// (RL3) period buffer hidden from software
// (RL4) period change at next period, or load
// (RL5) hardware never alters period holding register
// (RL6) enabled: width buffer loads at period end
// (RL7) disabled: width buffer loads next clock
// (RL8) width buffer hidden from software
// (RL9) width change at next period, or load
// (RL10) hardware never alters width holding register
// (RL11) counter readable, writes ignored
// (RL12) counter resets to one, held while disabled
// (RL13) enable rise: pulse, prescaler, count, flag
// (RL14) pin follows flip-flop and polarity
// (RL15) software ends with a zero-width period
// (RL16) count per tick, compare period and width
// (RL17) period, width and counter sixteen bits
package pwb_pkg;
	// ==========================================
	// register map, byte offsets inside the submodule
	localparam int DATA_W = 16;
	localparam int ADDR_W = 3;
	localparam logic [ADDR_W-1:0] OFS_CTRL = 3'h0;
	localparam logic [ADDR_W-1:0] OFS_PERIOD = 3'h2;
	localparam logic [ADDR_W-1:0] OFS_WIDTH = 3'h4;
	localparam logic [ADDR_W-1:0] OFS_COUNT = 3'h6;
	// ==========================================
	// status / control field positions
	localparam int CTRL_CLK_LSB = 0;
	localparam int CLK_SEL_W = 3;
	localparam int CTRL_EN = 3;
	localparam int CTRL_POLARITY = 4;
	localparam int CTRL_LOAD = 5;
	localparam int CTRL_FLAG = 15;
	// ==========================================
	// reset values and prescaler size
	localparam logic [DATA_W-1:0] CNT_RESET = 16'h0001;
	localparam logic [DATA_W-1:0] HOLD_RESET = 16'h0000;
	localparam int PRE_W = 9;
	localparam logic [PRE_W-1:0] PRE_ZERO = 9'h000;
	localparam logic [CLK_SEL_W-1:0] CLK_SEL_MAX = 3'h7;
	localparam logic [PRE_W-1:0] PRE_MASK_MAX = 9'h1ff;
endpackage : pwb_pkg

// ==== rtl/pwb_pre_if.sv ====
/*
 * Link between the PWM core and its prescaler.
 * Assumes both ends share the system clock.
 */
interface pwb_pre_if;
	logic run;
	logic [pwb_pkg::CLK_SEL_W-1:0] clk_sel;
	logic tick;
	modport core (output run, output clk_sel, input tick);
	modport pre (input run, input clk_sel, output tick);
endinterface : pwb_pre_if

// ==== rtl/pwb_prescaler.sv ====
/*
 * Counter clock prescaler: system clock / 2 up to / 512.
 * Assumes run drops whenever the submodule is disabled.
 */
module pwb_prescaler (
	// clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// core link
	pwb_pre_if.pre lnk
);
	// ==========================================
	// rate decoding
	// mask of low counter bits that must all be one for a tick
	function automatic logic [pwb_pkg::PRE_W-1:0] rate_mask(
		input logic [pwb_pkg::CLK_SEL_W-1:0] sel);
		logic [pwb_pkg::PRE_W-1:0] m;
		m = pwb_pkg::PRE_MASK_MAX;
		if (sel != pwb_pkg::CLK_SEL_MAX) begin
			m = pwb_pkg::PRE_MASK_MAX >> (pwb_pkg::PRE_W - 1 - int'(sel));
		end
		return m;
	endfunction

	logic [pwb_pkg::PRE_W-1:0] div_r;
	logic [pwb_pkg::PRE_W-1:0] mask;

	// divider held in reset while the submodule is off (RL13)
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			div_r <= pwb_pkg::PRE_ZERO;
		end else if (!lnk.run) begin
			div_r <= pwb_pkg::PRE_ZERO; // RL13
		end else begin
			div_r <= div_r + 9'h001;
		end
	end

	// rate may change at any time; a tick can then be early once
	assign mask = rate_mask(lnk.clk_sel);
	assign lnk.tick = lnk.run && ((div_r & mask) == mask);
endmodule // pwb_prescaler

// ==== rtl/pwb_top.sv ====
/*
 * Double-buffered PWM period and pulse width with a read-only counter.
 * Assumes a simple synchronous register port driven by software and
 * full 16-bit accesses; reads answer one clock after the strobe.
 */
module pwb_top (
	// clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// register port
	input wire logic [pwb_pkg::ADDR_W-1:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [pwb_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_rd,
	output logic [pwb_pkg::DATA_W-1:0] reg_rdata,
	// pwm pin
	output logic pwm_out
);
	// ==========================================
	// declarations
	logic [pwb_pkg::DATA_W-1:0] per_hold_r; // RL17
	logic [pwb_pkg::DATA_W-1:0] wid_hold_r;
	logic [pwb_pkg::DATA_W-1:0] per_buf_r;
	logic [pwb_pkg::DATA_W-1:0] wid_buf_r;
	logic [pwb_pkg::DATA_W-1:0] cnt_r;
	logic [pwb_pkg::DATA_W-1:0] cnt_nxt;
	logic [pwb_pkg::DATA_W-1:0] rdata_r;
	logic [pwb_pkg::CLK_SEL_W-1:0] clk_sel_r;
	logic en_r;
	logic en_d_r;
	logic polarity_r;
	logic flag_r;
	logic ff_r;
	logic wr_ctrl;
	logic wr_per;
	logic wr_wid;
	logic load_req;
	logic start;
	logic tick;
	logic period_end;
	logic width_hit;
	logic buf_load;

	pwb_pre_if pre_lnk ();

	// ==========================================
	// prescaler
	assign pre_lnk.run = en_r;
	assign pre_lnk.clk_sel = clk_sel_r;
	assign tick = pre_lnk.tick;

	pwb_prescaler u_pre (
		.clock(clock),
		.arst_n(arst_n),
		.lnk(pre_lnk)
	);

	// ==========================================
	// write decode
	assign wr_ctrl = reg_wr && (reg_addr == pwb_pkg::OFS_CTRL);
	assign wr_per = reg_wr && (reg_addr == pwb_pkg::OFS_PERIOD);
	assign wr_wid = reg_wr && (reg_addr == pwb_pkg::OFS_WIDTH);
	// load bit is a strobe; it is never stored
	assign load_req = wr_ctrl && reg_wdata[pwb_pkg::CTRL_LOAD];

	// control bits
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			en_r <= 1'b0;
			polarity_r <= 1'b0;
			clk_sel_r <= '0;
		end else if (wr_ctrl) begin
			en_r <= reg_wdata[pwb_pkg::CTRL_EN];
			polarity_r <= reg_wdata[pwb_pkg::CTRL_POLARITY];
			clk_sel_r <= reg_wdata[pwb_pkg::CTRL_CLK_LSB +: pwb_pkg::CLK_SEL_W];
		end
	end

	// previous enable, for the rising edge
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			en_d_r <= 1'b0;
		end else begin
			en_d_r <= en_r;
		end
	end
	assign start = en_r && !en_d_r;

	// holding registers change only by software writes
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			per_hold_r <= pwb_pkg::HOLD_RESET;
			wid_hold_r <= pwb_pkg::HOLD_RESET;
		end else begin
			if (wr_per) begin
				per_hold_r <= reg_wdata; // RL5 RL4
			end
			if (wr_wid) begin
				wid_hold_r <= reg_wdata; // RL10 RL9
			end
		end
	end

	// ==========================================
	// counter and compare
	assign period_end = en_r && tick && (cnt_r == per_buf_r); // RL16
	assign width_hit = en_r && tick && (cnt_r == wid_buf_r); // RL16

	// next count: held at one while off, wraps at period end
	always_comb begin
		cnt_nxt = cnt_r;
		if (!en_r) begin
			cnt_nxt = pwb_pkg::CNT_RESET; // RL12
		end else if (period_end) begin
			cnt_nxt = pwb_pkg::CNT_RESET; // RL16
		end else if (tick) begin
			cnt_nxt = cnt_r + 16'h0001; // RL16
		end
	end

	// counter register, never written by software
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			cnt_r <= pwb_pkg::CNT_RESET; // RL12
		end else begin
			cnt_r <= cnt_nxt; // RL11
		end
	end

	// ==========================================
	// hidden buffers, no read or write path from software
	// off: follow holding every clock; on: at period end or load
	assign buf_load = !en_r || period_end || load_req;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			per_buf_r <= pwb_pkg::HOLD_RESET;
			wid_buf_r <= pwb_pkg::HOLD_RESET;
		end else if (buf_load) begin
			per_buf_r <= per_hold_r; // RL1 RL2 RL3 RL4
			wid_buf_r <= wid_hold_r; // RL6 RL7 RL8 RL9
		end
	end

	// ==========================================
	// output flip-flop and pin
	// a period starts high at enable, and after a period end unless the new width is zero
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			ff_r <= 1'b0;
		end else if (!en_r) begin
			ff_r <= 1'b0; // RL14
		end else if (start) begin
			ff_r <= 1'b1; // RL13
		end else if (period_end) begin
			ff_r <= (wid_hold_r != pwb_pkg::HOLD_RESET); // RL16
		end else if (width_hit) begin
			ff_r <= 1'b0; // RL16
		end
	end

	// flip-flop is held low when off, so the pin rests at polarity
	assign pwm_out = ff_r ^ polarity_r; // RL14

	// flag: set on enable and each period end; write zero clears, set wins
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			flag_r <= 1'b0;
		end else if (start || period_end) begin
			flag_r <= 1'b1; // RL13
		end else if (wr_ctrl && !reg_wdata[pwb_pkg::CTRL_FLAG]) begin
			flag_r <= 1'b0;
		end
	end

	// ==========================================
	// read path, registered
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rdata_r <= '0;
		end else if (reg_rd) begin
			case (reg_addr)
				pwb_pkg::OFS_CTRL: begin
					rdata_r <= '0;
					rdata_r[pwb_pkg::CTRL_FLAG] <= flag_r;
					rdata_r[pwb_pkg::CTRL_POLARITY] <= polarity_r;
					rdata_r[pwb_pkg::CTRL_EN] <= en_r;
					rdata_r[pwb_pkg::CTRL_CLK_LSB +: pwb_pkg::CLK_SEL_W] <= clk_sel_r;
				end
				pwb_pkg::OFS_PERIOD: begin
					rdata_r <= per_hold_r;
				end
				pwb_pkg::OFS_WIDTH: begin
					rdata_r <= wid_hold_r;
				end
				pwb_pkg::OFS_COUNT: begin
					rdata_r <= cnt_r; // RL11
				end
				default: begin
					rdata_r <= '0;
				end
			endcase
		end
	end
	assign reg_rdata = rdata_r;

	// ==========================================
	// assertions
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);

	sequence s_enable_rise;
		en_r && !en_d_r;
	endsequence

	sequence s_first_pulse;
		ff_r && flag_r && (cnt_r == pwb_pkg::CNT_RESET);
	endsequence

	a_count_held_off: assert property (!en_r |=> cnt_r == pwb_pkg::CNT_RESET) // RL12
		else $error("counter not held at one while disabled");
	a_period_copy_off: assert property (!en_r |=> per_buf_r == $past(per_hold_r)) // RL2
		else $error("period buffer missed copy while disabled");
	a_width_copy_off: assert property (!en_r |=> wid_buf_r == $past(wid_hold_r)) // RL7
		else $error("width buffer missed copy while disabled");
	a_period_end_load: assert property (period_end |=> per_buf_r == $past(per_hold_r)) // RL1
		else $error("period buffer not loaded at period end");
	a_width_end_load: assert property (period_end |=> wid_buf_r == $past(wid_hold_r)) // RL6
		else $error("width buffer not loaded at period end");
	a_load_strobe: assert property (load_req |=> per_buf_r == $past(per_hold_r) // RL4 RL9
		&& wid_buf_r == $past(wid_hold_r))
		else $error("load strobe did not refresh buffers");
	a_hold_sw_only: assert property (!wr_per && !wr_wid |=> $stable(per_hold_r) // RL5 RL10
		&& $stable(wid_hold_r))
		else $error("holding register changed without a write");
	a_enable_start: assert property (s_enable_rise |=> s_first_pulse) // RL13
		else $error("enable rise did not start first pulse");
	a_pin_idle: assert property (!en_d_r && !en_r |=> pwm_out == polarity_r) // RL14
		else $error("idle pin level does not follow polarity");
	a_count_wrap: assert property (period_end |=> cnt_r == pwb_pkg::CNT_RESET // RL16
		##1 cnt_r <= per_buf_r || !en_r || $changed(per_buf_r))
		else $error("counter did not wrap at period end");
	a_count_read: assert property (reg_rd && reg_addr == pwb_pkg::OFS_COUNT // RL11
		|=> reg_rdata == $past(cnt_r))
		else $error("counter read returned wrong value");
endmodule // pwb_top

// ==== test/pwb_top_tb.sv ====
/*
 * Self-checking bench for the buffered PWM period / pulse-width block.
 * Assumes pwb_top with its plain register port and the pwb_pkg constants.
 */
module pwb_top_tb;
	timeunit 1ns;
	timeprecision 100ps;

	// ==========================================
	// stimulus and observed signals
	logic clock;
	logic arst_n;
	logic [pwb_pkg::ADDR_W-1:0] reg_addr;
	logic reg_wr;
	logic [pwb_pkg::DATA_W-1:0] reg_wdata;
	logic reg_rd;
	logic [pwb_pkg::DATA_W-1:0] reg_rdata;
	logic pwm_out;
	int err_total;
	int samples_checked;
	logic [15:0] rdv;
	logic [15:0] hi;
	localparam logic [15:0] EN = 16'h0001 << pwb_pkg::CTRL_EN;
	localparam logic [15:0] OUT_INV = 16'h0001 << pwb_pkg::CTRL_POLARITY;
	localparam logic [15:0] FLG = 16'h0001 << pwb_pkg::CTRL_FLAG;
	// prescaler select 0 gives one counter tick every two clocks
	localparam int TPC = 2;

	pwb_top u_dut (
		.clock(clock),
		.arst_n(arst_n),
		.reg_addr(reg_addr),
		.reg_wr(reg_wr),
		.reg_wdata(reg_wdata),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.pwm_out(pwm_out)
	);

	// ==========================================
	// 125 MHz system clock
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	// ==========================================
	// closing report, the single exit of the run
	task automatic end_sim();
		$display("checks %0d, mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// compare one 16-bit result
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one register write, strobe held for a single edge
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask

	// one register read; data settles just after the strobe's edge
	task automatic rd(input logic [2:0] a, output logic [15:0] d);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	// count clocks with the pin high over a fixed window
	task automatic meas(input int n, output logic [15:0] h);
		h = 16'h0000;
		repeat (n) begin
			@(negedge clock);
			if (pwm_out === 1'b1) h++;
		end
	endtask

	// bounded poll of the flag bit after an enable
	task automatic wait_flag();
		int i;
		for (i = 0; i < 8; i++) begin
			rd(pwb_pkg::OFS_CTRL, rdv);
			if (rdv[pwb_pkg::CTRL_FLAG] === 1'b1) break;
		end
		if (i == 8) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, rdv, FLG);
			end_sim();
		end
	endtask

	// ==========================================
	// main sequence
	initial begin
		logic [15:0] wt [4];
		int p;
		wt = '{16'h0000, 16'h0002, 16'h0005, 16'h0007};
		p = 5;
		err_total = 0;
		samples_checked = 0;
		arst_n = 1'b0;
		reg_addr = '0;
		reg_wr = 1'b0;
		reg_wdata = '0;
		reg_rd = 1'b0;
		repeat (12) @(posedge clock);
		arst_n <= 1'b1;

		// reset values, read-only counter, unmapped place
		rd(pwb_pkg::OFS_COUNT, rdv); chk(rdv, 16'h0001);
		rd(pwb_pkg::OFS_PERIOD, rdv); chk(rdv, pwb_pkg::HOLD_RESET);
		rd(3'h1, rdv); chk(rdv, 16'h0000);
		wr(pwb_pkg::OFS_COUNT, 16'h1234);
		rd(pwb_pkg::OFS_COUNT, rdv); chk(rdv, 16'h0001);
		chk({15'h0000, pwm_out}, 16'h0000);
		$display("test reset done");

		// disabled: holding registers read back, pin follows polarity
		wr(pwb_pkg::OFS_PERIOD, 16'(p));
		wr(pwb_pkg::OFS_WIDTH, 16'hbeef);
		rd(pwb_pkg::OFS_PERIOD, rdv); chk(rdv, 16'(p));
		rd(pwb_pkg::OFS_WIDTH, rdv); chk(rdv, 16'hbeef);
		wr(pwb_pkg::OFS_CTRL, OUT_INV);
		@(negedge clock);
		chk({15'h0000, pwm_out}, 16'h0001);
		$display("test disabled done");

		// duty for each width and polarity; width loads while disabled
		for (int inv = 0; inv < 2; inv++) begin
			for (int k = 0; k < 4; k++) begin
				wr(pwb_pkg::OFS_CTRL, inv ? OUT_INV : 16'h0000);
				wr(pwb_pkg::OFS_WIDTH, wt[k]);
				wr(pwb_pkg::OFS_CTRL, EN | (inv ? OUT_INV : 16'h0000));
				wait_flag();
				repeat (3 * p * TPC) @(posedge clock);
				// four whole periods, so the window phase does not matter
				meas(4 * p * TPC, hi);
				rdv = 16'(4 * TPC * ((wt[k] > p) ? p : wt[k]));
				chk(inv ? 16'(4 * p * TPC) - hi : hi, rdv);
			end
		end
		$display("test duty done");

		// enabled: new period and width reach the pin after a period end
		wr(pwb_pkg::OFS_CTRL, 16'h0000);
		wr(pwb_pkg::OFS_WIDTH, 16'h0002);
		wr(pwb_pkg::OFS_CTRL, EN);
		wait_flag();
		wr(pwb_pkg::OFS_PERIOD, 16'h0003);
		wr(pwb_pkg::OFS_WIDTH, 16'h0001);
		repeat (4 * p * TPC) @(posedge clock);
		meas(4 * 3 * TPC, hi);
		chk(hi, 16'(4 * TPC));
		rd(pwb_pkg::OFS_COUNT, rdv);
		chk({15'h0000, rdv >= 16'h0001 && rdv <= 16'h0003}, 16'h0001);
		rd(pwb_pkg::OFS_PERIOD, rdv); chk(rdv, 16'h0003);
		rd(pwb_pkg::OFS_WIDTH, rdv); chk(rdv, 16'h0001);
		$display("test running update done");

		// slower counter clocks, select 1 and 7, same period 3 width 1
		for (int s = 1; s < 8; s += 6) begin
			int tk;
			tk = (s == 7) ? 512 : (2 << s);
			wr(pwb_pkg::OFS_CTRL, EN | (16'(s) << pwb_pkg::CTRL_CLK_LSB));
			// rate switch may give one odd tick, so settle two periods
			repeat (2 * 3 * tk) @(posedge clock);
			meas(4 * 3 * tk, hi);
			chk(hi, 16'(4 * tk));
		end
		$display("test clock select done");

		// load strobe with width 0: pin stays low for whole periods
		wr(pwb_pkg::OFS_WIDTH, 16'h0000);
		wr(pwb_pkg::OFS_CTRL, EN | (16'h0001 << pwb_pkg::CTRL_LOAD));
		// a pulse already high runs on to the period end, so skip past it
		repeat (3 * 3 * TPC) @(posedge clock);
		meas(4 * 3 * TPC, hi);
		chk(hi, 16'h0000);
		// disable again after zero-width periods: counter back to one, pin low
		wr(pwb_pkg::OFS_CTRL, 16'h0000);
		rd(pwb_pkg::OFS_COUNT, rdv); chk(rdv, 16'h0001);
		chk({15'h0000, pwm_out}, 16'h0000);
		$display("test load and disable done");
		end_sim();
	end
endmodule // pwb_top_tb
